/* logic/ptmr_pkg.sv */
package ptmr_pkg;
    // register byte offsets
    localparam logic [7:0] LOWER_CTRL_OFF = 8'h00;
    localparam logic [7:0] UPPER_CTRL_OFF = 8'h04;
    localparam logic [7:0] COUNT_LOW_OFF = 8'h08;
    localparam logic [7:0] COUNT_HIGH_OFF = 8'h0C;
    localparam logic [7:0] PERIOD_LOW_OFF = 8'h10;
    localparam logic [7:0] PERIOD_HIGH_OFF = 8'h14;
    localparam logic [7:0] IRQ_CTRL_OFF = 8'h18;
    localparam logic [7:0] STATUS_OFF = 8'h1C;
    // control field positions
    localparam int RUN_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int GATE_BIT = 6;
    localparam int PS_LSB = 4;
    localparam int PAIR_BIT = 3;
    localparam int CS_BIT = 1;
    localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
    localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    // irq control: enables bits 0,1 ; priorities bits 6:4 and 10:8
    localparam int IE_LO_BIT = 0;
    localparam int IE_HI_BIT = 1;
    localparam int IP_LO_LSB = 4;
    localparam int IP_HI_LSB = 8;
    localparam logic [15:0] IRQ_CTRL_MASK = 16'h0773;
    // status flags: bit0 lower match, bit1 upper match (write 1 to clear)
    localparam int FLAG_LO_BIT = 0;
    localparam int FLAG_HI_BIT = 1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    // prescale encodings
    localparam logic [1:0] PS_1 = 2'h0;
    localparam logic [1:0] PS_8 = 2'h1;
    localparam logic [1:0] PS_64 = 2'h2;
    localparam logic [7:0] DIV_1 = 8'h00;
    localparam logic [7:0] DIV_8 = 8'h07;
    localparam logic [7:0] DIV_64 = 8'h3F;
    localparam logic [7:0] DIV_256 = 8'hFF;

    typedef struct packed {
        logic run;
        logic idleStop;
        logic gate;
        logic [1:0] prescale;
        logic pairMode;
        logic clkSel;
    } ptmr_ctrl_t;

    typedef struct packed {
        logic intEnable;
        logic [2:0] intPriority;
        logic intReq;
    } ptmr_irq_t;
endpackage

/* logic/ptmr_paired_timer.sv */
// Behaviour
// - chained: lower timer is low word, upper timer is high word
// - chained: upper control ignored except idle-stop bit; lower control sets run, prescale, clock, gate
// - chained: lower clock and gate drive count; upper flag raises interrupt
// - 32-bit period is upper period high word, lower period low word
// - count registers expose running count, upper holds high word
// - unpaired: two independent 16-bit timers, no asynchronous counting
// - chained: 32-bit timer on internal clock or synchronous external counter
// - chained: interrupt on full 32-bit count equal to 32-bit period
// - both counts offered as time bases to capture and compare
// - converter trigger only from chained pair
// - prescale 11=1:256, 10=1:64, 01=1:8, 00=1:1
// - clock source bit selects clock; gating only with internal clock
// - chained counter starts and stops with lower run bit
// - unpaired: each timer interrupts on own match, own enable and priority
// - chained: runs in idle only when upper idle-stop bit clear
// - timers keep counting in idle per idle-stop settings
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module ptmr_paired_timer (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic lowerExtClockPin,
    input wire logic upperExtClockPin,
    input wire logic lowerGatePin,
    input wire logic upperGatePin,
    input wire logic cpuIdle,
    output logic [15:0] lowerTimeBase,
    output logic [15:0] upperTimeBase,
    output logic converterTrigger,
    output ptmr_pkg::ptmr_irq_t lowerIrq,
    output ptmr_pkg::ptmr_irq_t upperIrq
);
    logic [15:0] lowerCtrl_reg;
    logic [15:0] upperCtrl_reg;
    logic [15:0] periodLow_reg;
    logic [15:0] periodHigh_reg;
    logic [15:0] countLow_reg;
    logic [15:0] countHigh_reg;
    logic [15:0] irqCtrl_reg;
    logic [1:0] flag_reg;
    logic [7:0] preLow_reg;
    logic [7:0] preHigh_reg;
    logic [2:0] syncLow_reg;
    logic [2:0] syncHigh_reg;
    logic [1:0] gateSync0_reg;
    logic [1:0] gateSync1_reg;
    logic trig_reg;
    ptmr_pkg::ptmr_ctrl_t cLo;
    ptmr_pkg::ptmr_ctrl_t cHi;
    logic pair;
    logic runLo;
    logic runHi;
    logic edgeLo;
    logic edgeHi;
    logic srcLo;
    logic srcHi;
    logic [7:0] divLo;
    logic [7:0] divHi;
    logic tickLo;
    logic tickHi;
    logic matchLo;
    logic matchHi;
    logic match32;
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;
    logic [15:0] wVal;
    logic [1:0] clearFlags;

    function automatic ptmr_pkg::ptmr_ctrl_t unpackCtrl(input logic [15:0] v);
        ptmr_pkg::ptmr_ctrl_t c;
        c.run = v[ptmr_pkg::RUN_BIT];
        c.idleStop = v[ptmr_pkg::IDLE_BIT];
        c.gate = v[ptmr_pkg::GATE_BIT];
        c.prescale = v[ptmr_pkg::PS_LSB +: 2];
        c.pairMode = v[ptmr_pkg::PAIR_BIT];
        c.clkSel = v[ptmr_pkg::CS_BIT];
        return c;
    endfunction

    function automatic logic [7:0] divOf(input logic [1:0] ps);
        logic [7:0] d;
        d = ptmr_pkg::DIV_256;
        if (ps == ptmr_pkg::PS_1)
            d = ptmr_pkg::DIV_1;
        else if (ps == ptmr_pkg::PS_8)
            d = ptmr_pkg::DIV_8;
        else if (ps == ptmr_pkg::PS_64)
            d = ptmr_pkg::DIV_64;
        return d;
    endfunction

    assign cLo = unpackCtrl(lowerCtrl_reg);
    assign pair = cLo.pairMode;
    assign cHi = pair ? cLo : unpackCtrl(upperCtrl_reg);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            syncLow_reg <= 3'h0;
            syncHigh_reg <= 3'h0;
            gateSync0_reg <= 2'h0;
            gateSync1_reg <= 2'h0;
        end
        else
        begin
            syncLow_reg <= {syncLow_reg[1:0], lowerExtClockPin};
            syncHigh_reg <= {syncHigh_reg[1:0], upperExtClockPin};
            gateSync0_reg <= {gateSync0_reg[0], lowerGatePin};
            gateSync1_reg <= {gateSync1_reg[0], upperGatePin};
        end
    end
    assign edgeLo = syncLow_reg[1] & ~syncLow_reg[2];
    assign edgeHi = syncHigh_reg[1] & ~syncHigh_reg[2];

    // idle stop from upper bit when chained
    assign runLo = cLo.run & ~(cpuIdle & (pair ? upperCtrl_reg[ptmr_pkg::IDLE_BIT] : cLo.idleStop));
    assign runHi = ~pair & cHi.run & ~(cpuIdle & cHi.idleStop);

    // lower clock and gate in chained mode
    assign srcLo = cLo.clkSel ? edgeLo : (cLo.gate ? gateSync0_reg[1] : 1'b1);
    assign srcHi = cHi.clkSel ? edgeHi : (cHi.gate ? gateSync1_reg[1] : 1'b1);
    assign divLo = divOf(cLo.prescale);
    assign divHi = divOf(cHi.prescale);
    assign tickLo = runLo & srcLo & (preLow_reg == divLo);
    assign tickHi = runHi & srcHi & (preHigh_reg == divHi);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            preLow_reg <= 8'h00;
            preHigh_reg <= 8'h00;
        end
        else
        begin
            if (!runLo)
                preLow_reg <= 8'h00;
            else if (srcLo)
                preLow_reg <= (preLow_reg >= divLo) ? 8'h00 : preLow_reg + 8'h01;
            if (!runHi)
                preHigh_reg <= 8'h00;
            else if (srcHi)
                preHigh_reg <= (preHigh_reg >= divHi) ? 8'h00 : preHigh_reg + 8'h01;
        end
    end

    assign match32 = {countHigh_reg, countLow_reg} == {periodHigh_reg, periodLow_reg};
    assign matchLo = countLow_reg == periodLow_reg;
    assign matchHi = countHigh_reg == periodHigh_reg;

    // clear on match at next tick
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            countLow_reg <= 16'h0000;
            countHigh_reg <= 16'h0000;
        end
        else if (doWrite && awAddr_reg == ptmr_pkg::COUNT_LOW_OFF)
            countLow_reg <= wVal;
        else if (doWrite && awAddr_reg == ptmr_pkg::COUNT_HIGH_OFF)
            countHigh_reg <= wVal;
        else if (pair)
        begin
            if (tickLo)
            begin
                if (match32)
                    {countHigh_reg, countLow_reg} <= 32'h0000_0000;
                else
                    {countHigh_reg, countLow_reg} <= {countHigh_reg, countLow_reg} + 32'h0000_0001;
            end
        end
        else
        begin
            if (tickLo)
                countLow_reg <= matchLo ? 16'h0000 : countLow_reg + 16'h0001;
            if (tickHi)
                countHigh_reg <= matchHi ? 16'h0000 : countHigh_reg + 16'h0001;
        end
    end

    assign clearFlags = (doWrite && awAddr_reg == ptmr_pkg::STATUS_OFF) ? wVal[1:0] : 2'h0;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flag_reg <= 2'h0;
            trig_reg <= 1'b0;
        end
        else
        begin
            flag_reg[ptmr_pkg::FLAG_LO_BIT] <= (tickLo & ~pair & matchLo)
                | (flag_reg[ptmr_pkg::FLAG_LO_BIT] & ~clearFlags[ptmr_pkg::FLAG_LO_BIT]);
            flag_reg[ptmr_pkg::FLAG_HI_BIT] <= (pair ? (tickLo & match32) : (tickHi & matchHi))
                | (flag_reg[ptmr_pkg::FLAG_HI_BIT] & ~clearFlags[ptmr_pkg::FLAG_HI_BIT]);
            trig_reg <= pair & tickLo & match32;
        end
    end
    assign converterTrigger = trig_reg;

    assign lowerTimeBase = countLow_reg;
    assign upperTimeBase = countHigh_reg;

    assign lowerIrq.intEnable = irqCtrl_reg[ptmr_pkg::IE_LO_BIT];
    assign lowerIrq.intPriority = irqCtrl_reg[ptmr_pkg::IP_LO_LSB +: 3];
    assign lowerIrq.intReq = flag_reg[ptmr_pkg::FLAG_LO_BIT] & irqCtrl_reg[ptmr_pkg::IE_LO_BIT];
    assign upperIrq.intEnable = irqCtrl_reg[ptmr_pkg::IE_HI_BIT];
    assign upperIrq.intPriority = irqCtrl_reg[ptmr_pkg::IP_HI_LSB +: 3];
    assign upperIrq.intReq = flag_reg[ptmr_pkg::FLAG_HI_BIT] & irqCtrl_reg[ptmr_pkg::IE_HI_BIT];

    // axi write path
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
    assign wVal = {wStrb_reg[1] ? wData_reg[15:8] : 8'h00, wStrb_reg[0] ? wData_reg[7:0] : 8'h00};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ptmr_pkg::AXI_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg > ptmr_pkg::STATUS_OFF) ? ptmr_pkg::AXI_SLVERR : ptmr_pkg::AXI_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // merge keeps unwritten byte lanes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
        logic [15:0] m;
        m = {wStrb_reg[1] ? wData_reg[15:8] : old[15:8], wStrb_reg[0] ? wData_reg[7:0] : old[7:0]};
        return m & mask;
    endfunction

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lowerCtrl_reg <= ptmr_pkg::CTRL_RESET;
            upperCtrl_reg <= ptmr_pkg::CTRL_RESET;
            periodLow_reg <= ptmr_pkg::PERIOD_RESET;
            periodHigh_reg <= ptmr_pkg::PERIOD_RESET;
            irqCtrl_reg <= 16'h0000;
        end
        else if (doWrite)
        begin
            if (awAddr_reg == ptmr_pkg::LOWER_CTRL_OFF)
                lowerCtrl_reg <= merge(lowerCtrl_reg, ptmr_pkg::LOWER_CTRL_MASK);
            else if (awAddr_reg == ptmr_pkg::UPPER_CTRL_OFF)
                upperCtrl_reg <= merge(upperCtrl_reg, ptmr_pkg::UPPER_CTRL_MASK);
            else if (awAddr_reg == ptmr_pkg::PERIOD_LOW_OFF)
                periodLow_reg <= merge(periodLow_reg, 16'hFFFF);
            else if (awAddr_reg == ptmr_pkg::PERIOD_HIGH_OFF)
                periodHigh_reg <= merge(periodHigh_reg, 16'hFFFF);
            else if (awAddr_reg == ptmr_pkg::IRQ_CTRL_OFF)
                irqCtrl_reg <= merge(irqCtrl_reg, ptmr_pkg::IRQ_CTRL_MASK);
        end
    end

    // axi read path
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ptmr_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ptmr_pkg::AXI_OKAY;
            if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::LOWER_CTRL_OFF)
                s_axi_rdata <= {16'h0000, lowerCtrl_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::UPPER_CTRL_OFF)
                s_axi_rdata <= {16'h0000, upperCtrl_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::COUNT_LOW_OFF)
                s_axi_rdata <= {16'h0000, countLow_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::COUNT_HIGH_OFF)
                s_axi_rdata <= {16'h0000, countHigh_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::PERIOD_LOW_OFF)
                s_axi_rdata <= {16'h0000, periodLow_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::PERIOD_HIGH_OFF)
                s_axi_rdata <= {16'h0000, periodHigh_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::IRQ_CTRL_OFF)
                s_axi_rdata <= {16'h0000, irqCtrl_reg};
            else if ({s_axi_araddr[7:2], 2'h0} == ptmr_pkg::STATUS_OFF)
                s_axi_rdata <= {30'h0000_0000, flag_reg};
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= ptmr_pkg::AXI_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

/* verification/ptmr_timer_properties.sv */
`timescale 1ns/100ps
module ptmr_timer_properties (
    input logic clk,
    input logic srst,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [15:0] lowerTimeBase,
    input logic [15:0] upperTimeBase,
    input logic converterTrigger,
    input ptmr_pkg::ptmr_irq_t lowerIrq,
    input ptmr_pkg::ptmr_irq_t upperIrq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_bHeld;
        s_axi_bvalid && $stable(s_axi_bresp);
    endsequence
    sequence s_rHeld;
        s_axi_rvalid && $stable(s_axi_rdata);
    endsequence
    sequence s_zeroNow;
        lowerTimeBase == 16'h0 && upperTimeBase == 16'h0;
    endsequence
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_bHeld)
        else $error("write response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_rHeld)
        else $error("read data dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_trig_zero: assert property (converterTrigger |-> s_zeroNow or ##1 s_zeroNow)
        else $error("trigger without 32-bit wrap");
    a_trig_irq: assert property (converterTrigger && upperIrq.intEnable |-> ##[0:1] upperIrq.intReq)
        else $error("chained match not on upper interrupt");
    a_lower_gated: assert property (lowerIrq.intReq |-> lowerIrq.intEnable)
        else $error("lower request without enable");
    a_upper_gated: assert property (upperIrq.intReq |-> upperIrq.intEnable)
        else $error("upper request without enable");
    a_lower_step: assert property (!s_axi_bvalid && lowerTimeBase != $past(lowerTimeBase)
        |-> lowerTimeBase == $past(lowerTimeBase) + 16'h1 || lowerTimeBase == 16'h0)
        else $error("lower count jumped");
    a_upper_step: assert property (!s_axi_bvalid && upperTimeBase != $past(upperTimeBase)
        |-> upperTimeBase == $past(upperTimeBase) + 16'h1 || upperTimeBase == 16'h0)
        else $error("upper count jumped");
endmodule

/* verification/ptmr_pin_model.sv */
`timescale 1ns/100ps
module ptmr_pin_model (
    input logic clk,
    input logic gateLevel,
    output logic lowerExtClockPin = 1'b0,
    output logic upperExtClockPin = 1'b0,
    output logic lowerGatePin,
    output logic upperGatePin
);
    assign lowerGatePin = gateLevel;
    assign upperGatePin = gateLevel;
    // slow rising edges, clock stands low between bursts
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk);
            lowerExtClockPin <= 1'b1;
            upperExtClockPin <= 1'b1;
            repeat (4) @(posedge clk);
            lowerExtClockPin <= 1'b0;
            upperExtClockPin <= 1'b0;
        end
    endtask
endmodule

/* verification/ptmr_paired_timer_bench.sv */
`timescale 1ns/100ps
module ptmr_paired_timer_bench;
    logic clk = 1'b0, srst = 1'b1, cpuIdle = 1'b0, gateLevel = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, converterTrigger;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic lowerExtClockPin, upperExtClockPin, lowerGatePin, upperGatePin;
    logic [15:0] lowerTimeBase, upperTimeBase;
    ptmr_pkg::ptmr_irq_t lowerIrq, upperIrq;
    // holds bready/rready low until the answer shows, so the answer must stand
    logic lateReady = 1'b0;
    int fail_count = 0, checks_done = 0, cycles = 0, trigCount = 0;
    ptmr_paired_timer uut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .lowerExtClockPin, .upperExtClockPin, .lowerGatePin, .upperGatePin, .cpuIdle,
        .lowerTimeBase, .upperTimeBase, .converterTrigger, .lowerIrq, .upperIrq);
    ptmr_pin_model pins (.clk, .gateLevel, .lowerExtClockPin, .upperExtClockPin, .lowerGatePin,
        .upperGatePin);
    always #2 clk = ~clk;
    always @(negedge clk)
        if (converterTrigger === 1'b1) trigCount++;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic aT, wT, arT, bT, rT, bv, rv;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w && !lateReady;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w && !lateReady;
        do
        begin
            @(negedge clk);
            aT = s_axi_awvalid && s_axi_awready;
            wT = s_axi_wvalid && s_axi_wready;
            arT = s_axi_arvalid && s_axi_arready;
            bT = s_axi_bvalid && s_axi_bready;
            rT = s_axi_rvalid && s_axi_rready;
            bv = s_axi_bvalid;
            rv = s_axi_rvalid;
            rs = w ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            @(posedge clk);
            if (aT) s_axi_awvalid <= 1'b0;
            if (wT) s_axi_wvalid <= 1'b0;
            if (arT) s_axi_arvalid <= 1'b0;
            if (bT) s_axi_bready <= 1'b0;
            else if (bv && w) s_axi_bready <= 1'b1;
            if (rT) s_axi_rready <= 1'b0;
            else if (rv && !w) s_axi_rready <= 1'b1;
        end
        while (!(bT || rT));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string msg);
        acc(1'b0, a, 32'h0);
        check(rd, e, msg);
    endtask
    task automatic clr;
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h0);
        wr(ptmr_pkg::UPPER_CTRL_OFF, 32'h0);
        wr(ptmr_pkg::COUNT_LOW_OFF, 32'h0);
        wr(ptmr_pkg::COUNT_HIGH_OFF, 32'h0);
        wr(ptmr_pkg::STATUS_OFF, 32'h3);
    endtask
    task automatic t_reset;
        rdchk(ptmr_pkg::LOWER_CTRL_OFF, 32'h0, "ctrl reset");
        rdchk(ptmr_pkg::PERIOD_HIGH_OFF, 32'hFFFF, "period reset");
        lateReady = 1'b1;
        wr(8'h20, 32'h1);
        check(rs, ptmr_pkg::AXI_SLVERR, "unmapped write");
        rdchk(8'h20, 32'h0, "unmapped read");
        check(rs, ptmr_pkg::AXI_SLVERR, "unmapped read resp");
        lateReady = 1'b0;
        $display("reset test done");
    endtask
    task automatic t_single;
        wr(ptmr_pkg::PERIOD_LOW_OFF, 32'h3);
        wr(ptmr_pkg::IRQ_CTRL_OFF, 32'h51);
        trigCount = 0;
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8000);
        repeat (20) @(posedge clk);
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h0);
        check(lowerIrq, 5'h1B, "lower irq");
        check(upperIrq.intReq, 1'b0, "upper irq idle");
        check(trigCount, 0, "no trigger alone");
        check(lowerTimeBase <= 16'h3, 1'b1, "wrap at period");
        rdchk(ptmr_pkg::COUNT_LOW_OFF, lowerTimeBase, "stopped count");
        rdchk(ptmr_pkg::STATUS_OFF, 32'h1, "lower flag");
        wr(ptmr_pkg::STATUS_OFF, 32'h1);
        rdchk(ptmr_pkg::STATUS_OFF, 32'h0, "flag cleared");
        $display("single test done");
    endtask
    task automatic t_chain;
        clr();
        // pairing first, run last; upper interrupt enabled
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8);
        wr(ptmr_pkg::UPPER_CTRL_OFF, 32'h8030);
        wr(ptmr_pkg::COUNT_LOW_OFF, 32'hFFF0);
        wr(ptmr_pkg::PERIOD_LOW_OFF, 32'h2);
        wr(ptmr_pkg::PERIOD_HIGH_OFF, 32'h1);
        wr(ptmr_pkg::IRQ_CTRL_OFF, 32'h302);
        trigCount = 0;
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8008);
        repeat (40) @(posedge clk);
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8);
        check(trigCount, 1, "one 32-bit match");
        check(upperIrq, 5'h17, "upper irq");
        rdchk(ptmr_pkg::STATUS_OFF, 32'h2, "upper flag only");
        rdchk(ptmr_pkg::COUNT_HIGH_OFF, 32'h0, "high word wrapped");
        check(upperTimeBase, 16'h0, "upper time base");
        rdchk(ptmr_pkg::COUNT_LOW_OFF, lowerTimeBase, "low word");
        check(lowerTimeBase > 16'h10, 1'b1, "low kept lower ctrl rate");
        wr(ptmr_pkg::PERIOD_LOW_OFF, 32'hFFFF);
        wr(ptmr_pkg::PERIOD_HIGH_OFF, 32'hFFFF);
        clr();
        $display("chain test done");
    endtask
    task automatic t_presc;
        int divs[4] = '{1, 8, 64, 256};
        for (int i = 0; i < 4; i++)
        begin
            wr(ptmr_pkg::COUNT_LOW_OFF, 32'h0);
            wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8000 | (i << 4));
            repeat (5 * divs[i]) @(posedge clk);
            wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h0);
            acc(1'b0, ptmr_pkg::COUNT_LOW_OFF, 32'h0);
            check(rd >= 5 && rd <= (i > 0 ? 6 : 15), 1'b1, "prescaled count");
        end
        $display("prescale test done");
    endtask
    task automatic t_ext;
        clr();
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8002);
        wr(ptmr_pkg::UPPER_CTRL_OFF, 32'h8002);
        pins.pulses(6);
        repeat (8) @(posedge clk);
        check(lowerTimeBase, 16'h6, "lower external edges");
        check(upperTimeBase, 16'h6, "upper external edges");
        clr();
        $display("external test done");
    endtask
    task automatic t_gate_idle;
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'h8040);
        repeat (20) @(posedge clk);
        check(lowerTimeBase, 16'h0, "gate closed");
        gateLevel <= 1'b1;
        repeat (10) @(posedge clk);
        gateLevel <= 1'b0;
        repeat (6) @(posedge clk);
        check(lowerTimeBase >= 8 && lowerTimeBase <= 12, 1'b1, "gate open");
        clr();
        wr(ptmr_pkg::LOWER_CTRL_OFF, 32'hA000);
        wr(ptmr_pkg::UPPER_CTRL_OFF, 32'h8000);
        cpuIdle <= 1'b1;
        repeat (4) @(posedge clk);
        rd = {lowerTimeBase, upperTimeBase};
        repeat (10) @(posedge clk);
        check(lowerTimeBase, rd[31:16], "idle stop freezes");
        check(upperTimeBase == rd[15:0], 1'b0, "idle keeps running");
        cpuIdle <= 1'b0;
        clr();
        $display("gate and idle test done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_single();
        t_chain();
        t_presc();
        t_ext();
        t_gate_idle();
        wrap_up();
    end
endmodule
bind ptmr_paired_timer ptmr_timer_properties u_props (.clk, .srst, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .lowerTimeBase,
    .upperTimeBase, .converterTrigger, .lowerIrq, .upperIrq);
